// [dds_ctl.sv]
// Purpose: System controller model driving the serial port and update strobe
// Assumes: Serial clock stalls low; high half period is 6 core cycles, low half 7
// Notes: Released data line toggles so stale values cannot pass
`timescale 1ns/10ps

module dds_ctl (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic sclk,
  output logic chip_select_n,
  output logic sdio_drv,
  output logic port_abort,
  input wire logic sdio_out,
  input wire logic separate_serial_output,
  // Update strobe
  output logic io_update
);
  logic lsb = 1'b0;
  logic sep = 1'b0;

  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    sdio_drv = 1'b0;
    port_abort = 1'b0;
    io_update = 1'b0;
  end

  // One bit: drive, sample read data, then rise and fall
  task automatic bit_io(input logic d, input logic rd, output logic q);
    @(negedge clk);
    sdio_drv = rd ? ~sdio_drv : d;
    repeat (6) @(negedge clk);
    q = sep ? separate_serial_output : sdio_out;
    sclk = 1'b1;
    repeat (6) @(negedge clk);
    sclk = 1'b0;
  endtask : bit_io

  // Instruction (ni bits) then nb data bytes as one bit stream
  task automatic xfer(input int ni, input logic [7:0] ins, input logic [31:0] wd,
                      input int nb, output logic [31:0] rd);
    logic q;
    chip_select_n = 1'b0;
    rd = '0;
    for (int i = 0; i < ni; i++) bit_io(ins[lsb ? i : 7 - i], 1'b0, q);
    for (int i = 0; i < nb * 8; i++) begin
      bit_io(wd[lsb ? i : nb * 8 - 1 - i], ins[7], q);
      rd[lsb ? i : nb * 8 - 1 - i] = q;
    end
  endtask : xfer

  task automatic deselect();
    @(negedge clk);
    chip_select_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask : deselect

  task automatic abort();
    @(negedge clk);
    port_abort = 1'b1;
    repeat (8) @(negedge clk);
    port_abort = 1'b0;
    repeat (8) @(negedge clk);
  endtask : abort

  task automatic strobe();
    @(negedge clk);
    io_update = 1'b1;
    repeat (16) @(negedge clk);
    io_update = 1'b0;
    repeat (12) @(negedge clk);
  endtask : strobe
endmodule : dds_ctl

// [dds_pkg.sv]
// Purpose: Types shared by the synthesizer serial port
// Assumes: Constants come from dds_regs.svh
// Notes: Active register image travels as one packed struct
package dds_pkg;
  typedef enum logic {PH_INSTR, PH_DATA} dds_phase_t;

  typedef struct packed {
    logic [31:0] first_control_register;
    logic [23:0] second_control_register;
    logic [15:0] asf;
    logic [7:0] arr;
    logic [31:0] ftw;
    logic [15:0] pow;
  } dds_ctrl_t;
endpackage : dds_pkg

// [dds_regs.svh]
// Purpose: Constants for the synthesizer serial port and update logic
// Assumes: Core sample clock is clk at 50 MHz
// Notes: Register indices are the five-bit register select values
//
// Notes on behaviour
// - Core clock divided by four drives the divided clock output pin.
// - Transfer strobe is sampled only on divided clock rising edges.
// - Serial writes fill buffers; active registers load only on strobe.
// - Each strobe rising edge yields exactly one load pulse.
// - Auto sync bit keeps divided clock phase locked to the phase reference.
// - Software sync bit advances divided clock one core cycle, then self-clears.
// - Hardware sync bit makes each reference rising edge advance one core cycle unless the auto sync bit is set.
// - Oscillator output pin stays static until its enable bit is set.
// - Accesses cover whole registers; device steps byte addresses itself.
// - First eight serial rising edges carry the instruction byte, then data.
// - Data phase byte count equals the addressed register width.
// - After the last data byte, next eight edges form a new instruction.
// - Data captured on serial clock rise, driven out on fall.
// - Instruction bit 7 high means read, low means write.
// - Instruction bits 6 and 5 ignored; bits 4 to 0 select register.
// - Both data pins are high impedance while chip select is high.
// - Chip select high suspends a cycle; it resumes when select returns.
// - Bit 9 of register 0 makes data pin input only when set.
// - In single-line mode the separate output pin is never driven.
// - Abort input ends the cycle and resets port state, not registers.
// - Bit 8 of register 0 selects least significant bit first.
// - LSB first steps bytes upward; otherwise bytes step downward.
`ifndef DDS_REGS_SVH
`define DDS_REGS_SVH

`define DDS_NREG 5'h06
`define DDS_IDX_FIRST_CONTROL_REGISTER 5'h00
`define DDS_IDX_SECOND_CONTROL_REGISTER 5'h01
`define DDS_IDX_ASF 5'h02
`define DDS_IDX_ARR 5'h03
`define DDS_IDX_FTW 5'h04
`define DDS_IDX_POW 5'h05
`define DDS_NB_FIRST_CONTROL_REGISTER 3'h4
`define DDS_NB_SECOND_CONTROL_REGISTER 3'h3
`define DDS_NB_ASF 3'h2
`define DDS_NB_ARR 3'h1
`define DDS_NB_FTW 3'h4
`define DDS_NB_POW 3'h2
`define DDS_NB_NONE 3'h1
`define DDS_RST_WORD 32'h00000000
`define DDS_B_AUTOSYNC 23
`define DDS_B_SWSYNC 22
`define DDS_B_SDIO_IN 9
`define DDS_B_LSBF 8
`define DDS_B_HSYNC 11
`define DDS_B_HWSYNC 10
`define DDS_B_OSC_EN 9
`define DDS_DIV_STEP 2'h1
`define DDS_AUTO_PHASE 2'h1

`endif

// [dds_spi.sv]
// Purpose: Serial control port, update strobe and divided clock sync
// Assumes: Pins sampled on clk; serial clock well below clk rate
// Notes: clk is the core sample clock
`timescale 1ns/10ps
`include "dds_regs.svh"

module dds_spi import dds_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Serial port pins
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic port_abort,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic separate_serial_output,
  output logic separate_serial_output_oe,
  // Update strobe and synchronisation
  input wire logic io_update,
  input wire logic sync_in,
  output logic sync_clk,
  // Oscillator pass-through
  input wire logic reference_clock_input,
  output logic osc_out,
  // Active control registers
  output dds_ctrl_t ctrl,
  output logic load_pulse
);

  // Pin synchronisers
  logic [6:0] s1_r;
  logic [6:0] s2_r;
  logic sclk_d_r;
  logic sync_in_d_r;
  logic sclk_s, cs_act, abort_s, din_s, upd_s, sync_in_s, ref_s;
  logic sclk_rise, sclk_fall, sync_in_rise;

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_r <= 7'h02;
      s2_r <= 7'h02;
    end else begin
      s1_r <= {reference_clock_input, sync_in, io_update, sdio_in, port_abort,
               chip_select_n, sclk};
      s2_r <= s1_r;
    end
  end

  assign sclk_s = s2_r[0];
  assign cs_act = ~s2_r[1];
  assign abort_s = s2_r[2];
  assign din_s = s2_r[3];
  assign upd_s = s2_r[4];
  assign sync_in_s = s2_r[5];
  assign ref_s = s2_r[6];

  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_d_r <= 1'b0;
      sync_in_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      sync_in_d_r <= sync_in_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;
  assign sync_in_rise = sync_in_s & ~sync_in_d_r;

  // Register storage
  logic [31:0] buf_r [0:5];
  logic [31:0] act_r [0:5];
  logic commit;
  logic [4:0] commit_addr;
  logic [31:0] commit_word;
  logic load_nxt;
  logic sw_adv_r;

  assign ctrl.first_control_register = act_r[0];
  assign ctrl.second_control_register = act_r[1][23:0];
  assign ctrl.asf = act_r[2][15:0];
  assign ctrl.arr = act_r[3][7:0];
  assign ctrl.ftw = act_r[4];
  assign ctrl.pow = act_r[5][15:0];

  // Divided clock
  logic [1:0] div_r;
  logic sc_d_r;
  logic sc_rise;
  logic auto_hit;
  logic hw_adv;

  assign auto_hit = act_r[0][`DDS_B_AUTOSYNC] & sync_in_rise;
  assign hw_adv = act_r[1][`DDS_B_HWSYNC] & sync_in_rise & ~act_r[0][`DDS_B_AUTOSYNC];

  always_ff @(posedge clk) begin
    if (srst) begin
      div_r <= 2'h0;
    end else if (auto_hit) begin
      div_r <= `DDS_AUTO_PHASE;
    end else begin
      // Each advance skips one core count
      div_r <= div_r + `DDS_DIV_STEP + {1'b0, sw_adv_r} + {1'b0, hw_adv};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sync_clk <= 1'b0;
      sc_d_r <= 1'b0;
    end else begin
      sync_clk <= ~div_r[1];
      sc_d_r <= sync_clk;
    end
  end

  assign sc_rise = sync_clk & ~sc_d_r;

  // Update strobe edge detection
  logic upd_smp_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      upd_smp_r <= 1'b0;
    end else if (sc_rise) begin
      upd_smp_r <= upd_s;
    end
  end

  assign load_nxt = sc_rise & upd_s & ~upd_smp_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      load_pulse <= 1'b0;
      sw_adv_r <= 1'b0;
    end else begin
      load_pulse <= load_nxt;
      sw_adv_r <= load_nxt & buf_r[0][`DDS_B_SWSYNC];
    end
  end

  // Buffer and active banks
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 6; i++) begin
        buf_r[i] <= `DDS_RST_WORD;
      end
    end else begin
      if (load_nxt) begin
        buf_r[0][`DDS_B_SWSYNC] <= 1'b0;
      end
      if (commit) begin
        buf_r[commit_addr[2:0]] <= commit_word;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 6; i++) begin
        act_r[i] <= `DDS_RST_WORD;
      end
    end else if (load_nxt) begin
      for (int i = 0; i < 6; i++) begin
        act_r[i] <= buf_r[i];
      end
      act_r[0][`DDS_B_SWSYNC] <= 1'b0;
    end
  end

  // Serial port
  function automatic logic [2:0] reg_bytes(input logic [4:0] a);
    unique case (a)
      `DDS_IDX_FIRST_CONTROL_REGISTER: reg_bytes = `DDS_NB_FIRST_CONTROL_REGISTER;
      `DDS_IDX_SECOND_CONTROL_REGISTER: reg_bytes = `DDS_NB_SECOND_CONTROL_REGISTER;
      `DDS_IDX_ASF: reg_bytes = `DDS_NB_ASF;
      `DDS_IDX_ARR: reg_bytes = `DDS_NB_ARR;
      `DDS_IDX_FTW: reg_bytes = `DDS_NB_FTW;
      `DDS_IDX_POW: reg_bytes = `DDS_NB_POW;
      default: reg_bytes = `DDS_NB_NONE;
    endcase
  endfunction : reg_bytes

  dds_phase_t phase_r;
  logic [2:0] bit_r;
  logic [1:0] byte_r;
  logic [7:0] sh_r;
  logic rw_r;
  logic [4:0] addr_r;
  logic [2:0] nb_r;
  logic [31:0] word_r;
  logic lsbf;
  logic in_only;
  logic step;
  logic [7:0] sh_nxt;
  logic [2:0] pos_tmp;
  logic [1:0] pos;
  logic [2:0] bi;
  logic last_byte;
  logic mapped;
  logic [31:0] word_ins;
  logic reading;

  assign lsbf = act_r[0][`DDS_B_LSBF];
  assign in_only = act_r[0][`DDS_B_SDIO_IN];
  assign step = sclk_rise & cs_act & ~abort_s;
  assign sh_nxt = lsbf ? {din_s, sh_r[7:1]} : {sh_r[6:0], din_s};
  assign pos_tmp = nb_r - 3'h1 - {1'b0, byte_r};
  assign pos = lsbf ? byte_r : pos_tmp[1:0];
  assign bi = lsbf ? bit_r : 3'h7 - bit_r;
  assign last_byte = ({1'b0, byte_r} == nb_r - 3'h1);
  assign mapped = (addr_r < `DDS_NREG);
  assign reading = cs_act & (phase_r == PH_DATA) & rw_r;

  always_comb begin
    word_ins = word_r;
    word_ins[{pos, 3'h0} +: 8] = sh_nxt;
  end

  assign commit = step & (bit_r == 3'h7) & (phase_r == PH_DATA) & last_byte & ~rw_r & mapped;
  assign commit_addr = addr_r;
  assign commit_word = word_ins;

  always_ff @(posedge clk) begin
    if (srst || abort_s) begin
      phase_r <= PH_INSTR;
      bit_r <= 3'h0;
      byte_r <= 2'h0;
      sh_r <= 8'h00;
      rw_r <= 1'b0;
      addr_r <= 5'h00;
      nb_r <= 3'h1;
      word_r <= 32'h00000000;
    end else if (step) begin
      bit_r <= bit_r + 3'h1;
      sh_r <= sh_nxt;
      if (bit_r == 3'h7) begin
        unique case (phase_r)
          PH_INSTR: begin
            phase_r <= PH_DATA;
            rw_r <= sh_nxt[7];
            addr_r <= sh_nxt[4:0];
            nb_r <= reg_bytes(sh_nxt[4:0]);
            byte_r <= 2'h0;
            word_r <= (sh_nxt[4:0] < `DDS_NREG) ? buf_r[sh_nxt[2:0]] : 32'h00000000;
          end
          PH_DATA: begin
            word_r <= rw_r ? word_r : word_ins;
            if (last_byte) begin
              phase_r <= PH_INSTR;
              byte_r <= 2'h0;
            end else begin
              byte_r <= byte_r + 2'h1;
            end
          end
        endcase
      end
    end
  end

  // Output pins
  always_ff @(posedge clk) begin
    if (srst || abort_s || !cs_act) begin
      sdio_oe <= 1'b0;
      separate_serial_output_oe <= 1'b0;
      sdio_out <= 1'b0;
      separate_serial_output <= 1'b0;
    end else if (sclk_fall) begin
      sdio_out <= word_r[{pos, bi}];
      separate_serial_output <= word_r[{pos, bi}];
      sdio_oe <= reading & ~in_only;
      separate_serial_output_oe <= reading & in_only;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      osc_out <= 1'b0;
    end else begin
      osc_out <= act_r[1][`DDS_B_OSC_EN] & ref_s;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_div_plain_step: assert property (
    !(sw_adv_r || hw_adv || auto_hit) |=> div_r == $past(div_r) + 2'h1)
    else $error("divider did not step by one");

  a_upd_on_sync: assert property (
    load_pulse |-> $past(sc_rise))
    else $error("load pulse not on divided clock rise");

  a_load_single: assert property (
    load_pulse |=> !load_pulse ##1 !load_pulse)
    else $error("load pulse repeated");

  a_load_copies: assert property (
    load_pulse |-> act_r[4] == $past(buf_r[4]))
    else $error("active word differs from buffer after load");

  a_hold_no_load: assert property (
    !load_pulse |-> $stable(act_r[4]) && $stable(act_r[1]))
    else $error("active word changed without load");

  a_sw_advance: assert property (
    (sw_adv_r && !hw_adv && !auto_hit) |=> div_r == $past(div_r) + 2'h2)
    else $error("software sync did not advance");

  a_sw_self_clear: assert property (
    load_pulse |-> !act_r[0][`DDS_B_SWSYNC])
    else $error("software sync bit not cleared");

  a_auto_phase: assert property (
    auto_hit |=> div_r == `DDS_AUTO_PHASE)
    else $error("auto sync phase not applied");

  a_cs_hiz: assert property (
    !cs_act |=> !sdio_oe && !separate_serial_output_oe)
    else $error("data pin driven without select");

  a_single_line: assert property (
    (!in_only && $stable(in_only)) |-> !separate_serial_output_oe)
    else $error("separate output driven in single line mode");

  a_osc_static: assert property (
    !act_r[1][`DDS_B_OSC_EN] |=> !osc_out)
    else $error("oscillator output toggled while disabled");

  a_abort_reset: assert property (
    abort_s |=> phase_r == PH_INSTR && bit_r == 3'h0)
    else $error("abort did not reset port");

  a_suspend_hold: assert property (
    (!cs_act && !abort_s) |=> $stable(bit_r) && $stable(phase_r) && $stable(byte_r))
    else $error("port moved while deselected");

  c_load: cover property (load_pulse);
  c_commit: cover property (commit);
  c_read_drive: cover property (sdio_oe ##1 sdio_oe);
  c_hw_sync: cover property (hw_adv);

endmodule : dds_spi

// [dds_spi_bench.sv]
// Purpose: Self-checking bench for the serial port and update logic
// Assumes: Controller model dds_ctl drives the serial pins
// Notes: Phase checks count core cycles between divided clock rises
`timescale 1ns/10ps

module dds_spi_bench import dds_pkg::*;;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic sclk, chip_select_n, port_abort, sdio_in, sdio_drv, io_update;
  logic sdio_out, sdio_oe, separate_serial_output, separate_serial_output_oe;
  logic sync_in = 1'b0;
  logic ref_in = 1'b0;
  logic sync_clk, osc_out, load_pulse, sep_line;
  logic oe_seen, sep_seen, osc_seen;
  dds_ctrl_t ctrl;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int loads = 0;
  logic [31:0] rd;

  always #10 clk = ~clk;
  always #35 ref_in = ~ref_in;
  assign sdio_in = sdio_oe ? sdio_out : sdio_drv;
  // Released separate line shows the inverse so an undriven read cannot pass
  assign sep_line = separate_serial_output_oe ? separate_serial_output : ~separate_serial_output;

  dds_spi u_dut (.clk(clk), .srst(srst), .sclk(sclk), .chip_select_n(chip_select_n),
    .port_abort(port_abort), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .separate_serial_output(separate_serial_output),
    .separate_serial_output_oe(separate_serial_output_oe), .io_update(io_update),
    .sync_in(sync_in), .sync_clk(sync_clk), .reference_clock_input(ref_in),
    .osc_out(osc_out), .ctrl(ctrl), .load_pulse(load_pulse));

  dds_ctl u_ctl (.clk(clk), .sclk(sclk), .chip_select_n(chip_select_n), .sdio_drv(sdio_drv),
    .port_abort(port_abort), .sdio_out(sdio_in),
    .separate_serial_output(sep_line), .io_update(io_update));

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (load_pulse === 1'b1) loads <= loads + 1;
    if (sdio_oe === 1'b1) oe_seen <= 1'b1;
    if (separate_serial_output_oe === 1'b1) sep_seen <= 1'b1;
    if (osc_out === 1'b1) osc_seen <= 1'b1;
  end

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Core cycle of the next divided clock rise
  task automatic rise(output int c);
    logic prev;
    prev = sync_clk;
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      if (sync_clk === 1'b1 && prev === 1'b0) begin
        c = cyc;
        return;
      end
      prev = sync_clk;
    end
    fails++;
    close_out();
  endtask : rise

  task automatic t_reset();
    int a, b;
    chk(ctrl.ftw, 32'h00000000);
    chk(ctrl.first_control_register, 32'h00000000);
    rise(a);
    rise(b);
    chk(b - a, 4);
  endtask : t_reset

  task automatic t_update();
    int l0;
    u_ctl.xfer(8, 8'h04, 32'hA5C30F69, 4, rd);
    u_ctl.xfer(8, 8'h02, 32'h00003C5A, 2, rd);
    u_ctl.xfer(8, 8'h03, 32'h00000096, 1, rd);
    u_ctl.xfer(8, 8'h05, 32'h00002B71, 2, rd);
    chk(ctrl.ftw, 32'h00000000);
    l0 = loads;
    u_ctl.strobe();
    chk(loads - l0, 1);
    chk(ctrl.ftw, 32'hA5C30F69);
    chk(ctrl.asf, 32'h00003C5A);
    chk(ctrl.arr, 32'h00000096);
    chk(ctrl.pow, 32'h00002B71);
  endtask : t_update

  task automatic t_read();
    sep_seen = 1'b0;
    oe_seen = 1'b0;
    u_ctl.xfer(8, 8'h01, 32'h00C351A5, 3, rd);
    u_ctl.xfer(8, 8'hE1, 32'h0, 3, rd);
    chk(rd, 32'h00C351A5);
    chk(oe_seen, 1'b1);
    chk(sep_seen, 1'b0);
    u_ctl.deselect();
    chk(sdio_oe, 1'b0);
  endtask : t_read

  task automatic t_break();
    u_ctl.xfer(8, 8'h04, 32'h00001357, 2, rd);
    u_ctl.deselect();
    chk(separate_serial_output_oe, 1'b0);
    u_ctl.xfer(0, 8'h00, 32'h00009BDF, 2, rd);
    u_ctl.xfer(8, 8'h84, 32'h0, 4, rd);
    chk(rd, 32'h13579BDF);
    u_ctl.xfer(8, 8'h04, 32'h0000FFFF, 2, rd);
    u_ctl.abort();
    u_ctl.xfer(8, 8'h84, 32'h0, 4, rd);
    chk(rd, 32'h13579BDF);
  endtask : t_break

  task automatic t_modes();
    u_ctl.xfer(8, 8'h00, 32'h00000300, 4, rd);
    u_ctl.strobe();
    u_ctl.lsb = 1'b1;
    u_ctl.sep = 1'b1;
    oe_seen = 1'b0;
    sep_seen = 1'b0;
    u_ctl.xfer(8, 8'h84, 32'h0, 4, rd);
    chk(rd, 32'h13579BDF);
    chk(oe_seen, 1'b0);
    chk(sep_seen, 1'b1);
    u_ctl.xfer(8, 8'h00, 32'h0, 4, rd);
    u_ctl.strobe();
    u_ctl.lsb = 1'b0;
    u_ctl.sep = 1'b0;
  endtask : t_modes

  task automatic t_sync();
    int a, b;
    rise(a);
    u_ctl.xfer(8, 8'h00, 32'h00400000, 4, rd);
    u_ctl.strobe();
    rise(b);
    chk((b - a) % 4, 3);
    chk(ctrl.first_control_register, 32'h00000000);
    u_ctl.xfer(8, 8'h01, 32'h00000400, 3, rd);
    u_ctl.strobe();
    rise(a);
    sync_in = 1'b1;
    repeat (8) @(negedge clk);
    sync_in = 1'b0;
    repeat (8) @(negedge clk);
    rise(b);
    chk((b - a) % 4, 3);
    chk(ctrl.second_control_register, 32'h00000400);
  endtask : t_sync

  // Auto sync: a reference rise puts the divided clock rise three cycles on
  task automatic t_auto();
    int c0, b;
    u_ctl.xfer(8, 8'h00, 32'h00800000, 4, rd);
    u_ctl.strobe();
    sync_in = 1'b1;
    c0 = cyc;
    repeat (8) @(negedge clk);
    rise(b);
    chk((b - c0) % 4, 3);
    sync_in = 1'b0;
    chk(ctrl.first_control_register, 32'h00800000);
  endtask : t_auto

  task automatic t_osc();
    chk(osc_seen, 1'b0);
    u_ctl.xfer(8, 8'h01, 32'h00000200, 3, rd);
    u_ctl.strobe();
    repeat (40) @(negedge clk);
    chk(osc_seen, 1'b1);
  endtask : t_osc

  initial begin
    repeat (6) @(negedge clk);
    srst = 1'b0;
    oe_seen = 1'b0;
    sep_seen = 1'b0;
    osc_seen = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_update();
    t_read();
    t_break();
    t_modes();
    t_sync();
    t_auto();
    t_osc();
    close_out();
  end
endmodule : dds_spi_bench
